// file: hrs_pkg.sv
// Purpose: constants and types for the home return sequencer
// Assumes: 20 MHz system clock, parameters presented as static inputs
// Notes:   register map is over APB, one 32-bit word per register
package hrs_pkg;

  // bus and data widths
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned POS_W   = 32;
  localparam int unsigned SPD_W   = 16;
  localparam int unsigned TRQ_W   = 16;
  localparam int unsigned ACC_W   = 16;
  localparam int unsigned DWELL_W = 16;
  localparam int unsigned REV_W   = 16;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CFG     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_HOMEPOS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SPEED   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DWELL   = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_TORQUE  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ACCEL   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_CURPOS  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_REVCNT  = 8'h24;

  // configuration and control field positions
  localparam int unsigned CFG_METHOD_LSB = 0;
  localparam int unsigned CFG_METHOD_W   = 4;
  localparam int unsigned CFG_DIR_BIT    = 4;
  localparam int unsigned CFG_INCR_BIT   = 5;
  localparam int unsigned CFG_STROKE_BIT = 6;
  localparam int unsigned CFG_ABSEN_BIT  = 7;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_CLRF_BIT  = 1;

  // method digits
  localparam logic [3:0] METH_DOG     = 4'h0;
  localparam logic [3:0] METH_COUNT   = 4'h1;
  localparam logic [3:0] METH_DATASET = 4'h2;
  localparam logic [3:0] METH_STOPPER = 4'h3;
  localparam logic [3:0] METH_IGNORE  = 4'h4;

  // reset values
  localparam logic [DATA_W-1:0] CFG_RST   = 32'h0000_0000;
  localparam logic [SPD_W-1:0]  SPEED_RST = 16'h0064;
  localparam logic [DWELL_W-1:0] DWELL_RST = 16'h0064;
  localparam logic [TRQ_W-1:0]  TRQ_RST   = 16'h0064;
  localparam logic [ACC_W-1:0]  ACC_RST   = 16'h0064;
  localparam logic [TRQ_W-1:0]  TRQ_FULL  = 16'hffff;

  // absolute revolution range
  localparam int REV_LIMIT = 32767;

  // dwell unit is 1 ms
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned DWELL_MS_NS = 1_000_000;
  localparam int unsigned CLK_NS      = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MS_CYCLES   = DWELL_MS_NS / CLK_NS;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'b000_0001,
    ST_SEEK    = 7'b000_0010,
    ST_BACKOFF = 7'b000_0100,
    ST_NORMAL  = 7'b000_1000,
    ST_PRESS   = 7'b001_0000,
    ST_DWELL   = 7'b010_0000,
    ST_FAULT   = 7'b100_0000
  } hrs_state_t;

endpackage : hrs_pkg

// file: hrs_dwell_timer.sv
// Purpose: millisecond dwell timer for stopper contact
// Assumes: cleared while run is low, counts whole milliseconds
// Notes:   done pulses high every other cycle from expiry while run stays high
`timescale 1ns/100ps
module hrs_dwell_timer #(
  parameter int unsigned MS_CYC = hrs_pkg::MS_CYCLES
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        run,
  input  wire logic [hrs_pkg::DWELL_W-1:0] dwellMs,
  output logic                             done
);
  import hrs_pkg::*;

  logic [23:0]         tickCnt_r;
  logic [DWELL_W-1:0]  msCnt_r;
  logic                done_r;

  // sub-millisecond prescaler and millisecond count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= 24'h00_0000;
      msCnt_r   <= '0;
      done_r    <= 1'b0;
    end else if (!run) begin
      tickCnt_r <= 24'h00_0000;
      msCnt_r   <= '0;
      done_r    <= 1'b0;
    end else if (done_r) begin
      done_r <= 1'b0;
    end else if (msCnt_r >= dwellMs) begin
      done_r <= 1'b1; // expiry
    end else if (tickCnt_r == 24'(MS_CYC - 1)) begin
      tickCnt_r <= 24'h00_0000;
      msCnt_r   <= msCnt_r + 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 1'b1;
    end
  end

  assign done = done_r;

endmodule // hrs_dwell_timer

// file: hrs_home_return_sequencer.sv
// Purpose: home return sequencer with APB register file
// Assumes: motion feedback inputs synchronous to clk_sys
// Notes:   dog and count searches run elsewhere; this block steers them
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
module hrs_home_return_sequencer (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [hrs_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [hrs_pkg::DATA_W-1:0]  pwdata,
  output logic [hrs_pkg::DATA_W-1:0]       prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        auto_manual_select,
  input  wire logic                        table_select_bit0,
  input  wire logic                        table_select_bit1,
  input  wire logic                        homeStart,
  input  wire logic                        servoOn,
  input  wire logic                        proxSwitch,
  input  wire logic                        limitFwd,
  input  wire logic                        limitRev,
  input  wire logic                        stopContact,
  input  wire logic                        searchDone,
  input  wire logic [hrs_pkg::POS_W-1:0]   encoderPos,
  input  wire logic                        absEraseAlarm,
  input  wire logic                        abs_counter_warning,
  output logic                             moveEn,
  output logic                             moveDirRev,
  output logic [hrs_pkg::SPD_W-1:0]        moveSpeed,
  output logic [hrs_pkg::ACC_W-1:0]        moveAccel,
  output logic [hrs_pkg::TRQ_W-1:0]        torqueLimit,
  output logic                             searchRun,
  output logic                             softLimitEn,
  output logic                             home_done,
  output logic                             homeFault,
  output logic                             absValid
);
  import hrs_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [DATA_W-1:0]  cfg_r;
  logic [POS_W-1:0]   homePos_r;
  logic [SPD_W-1:0]   speed_r;
  logic [DWELL_W-1:0] dwell_r;
  logic [TRQ_W-1:0]   torque_r;
  logic [ACC_W-1:0]   accel_r;
  logic               swStart;
  logic               swClrFault;
  logic               wrEn;
  logic               addrOk;
  // decoding shared by read and write paths
  function automatic logic hrsMapped(input logic [ADDR_W-1:0] a);
    case (a)
      REG_CFG, REG_HOMEPOS, REG_SPEED, REG_DWELL, REG_TORQUE,
      REG_ACCEL, REG_CTRL, REG_STATUS, REG_CURPOS, REG_REVCNT:
        hrsMapped = 1'b1;
      default: hrsMapped = 1'b0;
    endcase
  endfunction
  assign pready  = 1'b1;
  assign addrOk  = hrsMapped(paddr);
  assign pslverr = psel & penable & ~addrOk;
  assign wrEn    = psel & penable & pwrite & addrOk;
  assign swStart    = wrEn & (paddr == REG_CTRL) & pwdata[CTRL_START_BIT];
  assign swClrFault = wrEn & (paddr == REG_CTRL) & pwdata[CTRL_CLRF_BIT];
  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r     <= CFG_RST;
      homePos_r <= '0;
      speed_r   <= SPEED_RST;
      dwell_r   <= DWELL_RST;
      torque_r  <= TRQ_RST;
      accel_r   <= ACC_RST;
    end else if (wrEn) begin
      case (paddr)
        REG_CFG:     cfg_r     <= pwdata;
        REG_HOMEPOS: homePos_r <= pwdata;
        REG_SPEED:   speed_r   <= pwdata[SPD_W-1:0];
        REG_DWELL:   dwell_r   <= pwdata[DWELL_W-1:0];
        REG_TORQUE:  torque_r  <= pwdata[TRQ_W-1:0];
        REG_ACCEL:   accel_r   <= pwdata[ACC_W-1:0];
        default: ;
      endcase
    end
  end

  logic [3:0] method;
  logic       dirRev;
  logic       incrMode;
  logic       strokeless;
  logic       absEnable;
  assign method     = cfg_r[CFG_METHOD_LSB +: CFG_METHOD_W];
  assign dirRev     = cfg_r[CFG_DIR_BIT];
  assign incrMode   = cfg_r[CFG_INCR_BIT];
  assign strokeless = cfg_r[CFG_STROKE_BIT];
  assign absEnable  = cfg_r[CFG_ABSEN_BIT];
  ////////////////////////////////////////////////////////////////////////
  // sequencer
  hrs_state_t state_r;
  hrs_state_t state_nxt;
  logic       homeMode;
  logic       go;
  logic       servoOn_r;
  logic       dwellDone;
  logic       atFarLimit;
  logic       atNearLimit;
  logic       done_nxt;
  logic       sawProx_r;
  // home mode only with auto/manual high and table bits low
  assign homeMode = auto_manual_select & ~table_select_bit0
                  & ~table_select_bit1;
  assign go       = homeMode & (homeStart | swStart) & (state_r == ST_IDLE);
  assign atNearLimit = dirRev ? limitRev : limitFwd;
  assign atFarLimit  = dirRev ? limitFwd : limitRev;
  // next state
  always_comb begin
    state_nxt = state_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          case (method)
            METH_DOG, METH_COUNT: begin
              state_nxt = proxSwitch ? ST_BACKOFF : ST_SEEK;
            end
            METH_DATASET: done_nxt = 1'b1;
            METH_STOPPER: state_nxt = ST_PRESS;
            METH_IGNORE:  done_nxt = 1'b1;
            default: ;
          endcase
        end else if (homeMode && method == METH_IGNORE
                     && servoOn && !servoOn_r) begin
          done_nxt = 1'b1;
        end
      end
      ST_SEEK: begin
        if (atNearLimit) state_nxt = ST_BACKOFF;
        else if (searchDone) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      ST_BACKOFF: begin
        if (atFarLimit) state_nxt = ST_FAULT;
        else if (sawProx_r && !proxSwitch) state_nxt = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (atFarLimit) state_nxt = ST_FAULT;
        else if (searchDone) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      ST_PRESS: if (stopContact) state_nxt = ST_DWELL;
      ST_DWELL: begin
        if (dwellDone) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      ST_FAULT: if (swClrFault) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end
  // state register and servo-on edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      servoOn_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      servoOn_r <= servoOn;
    end
  end
  // backoff remembers passing the proximity switch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sawProx_r <= 1'b0;
    end else if (state_r != ST_BACKOFF) begin
      sawProx_r <= 1'b0;
    end else if (proxSwitch) begin
      sawProx_r <= 1'b1;
    end
  end

  hrs_dwell_timer u_dwell (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (state_r == ST_DWELL),
    .dwellMs (dwell_r),
    .done    (dwellDone)
  );

  ////////////////////////////////////////////////////////////////////////
  // position, done flag and absolute validity
  logic [POS_W-1:0] curPos_r;
  logic [POS_W-1:0] posBase_r;
  logic             homeDone_r;
  logic             fault_r;
  logic             absLost_r;
  // current position follows the encoder relative to the home offset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      posBase_r <= '0;
    end else if (done_nxt) begin
      posBase_r <= encoderPos - homePos_r;
    end
  end
  assign curPos_r = encoderPos - posBase_r;

  // home done drops at start and rises on completion, which wins in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      homeDone_r <= 1'b0;
    end else if (done_nxt) begin
      homeDone_r <= 1'b1;
    end else if (go || absEraseAlarm || abs_counter_warning) begin
      homeDone_r <= 1'b0;
    end
  end

  // fault sticks until cleared; a new fault wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (state_nxt == ST_FAULT) begin
      fault_r <= 1'b1;
    end else if (swClrFault) begin
      fault_r <= 1'b0;
    end
  end

  // absolute loss stays until a fresh home setting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      absLost_r <= 1'b0;
    end else if (absEraseAlarm || abs_counter_warning) begin
      absLost_r <= 1'b1;
    end else if (done_nxt) begin
      absLost_r <= 1'b0;
    end
  end

  // revolution count is the upper half of the position; its range check gates absolute valid
  logic [REV_W-1:0] revCnt;
  logic signed [POS_W-1:0] revFull;
  logic revInRange;
  assign revFull = $signed(curPos_r) >>> REV_W;
  assign revInRange = (revFull <= REV_LIMIT) && (revFull >= -REV_LIMIT);
  assign revCnt = revFull[REV_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // motion outputs
  logic autoRet;
  assign autoRet = (state_r == ST_SEEK) || (state_r == ST_BACKOFF)
                || (state_r == ST_NORMAL);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      moveEn      <= 1'b0;
      moveDirRev  <= 1'b0;
      moveSpeed   <= '0;
      moveAccel   <= '0;
      torqueLimit <= TRQ_FULL;
      searchRun   <= 1'b0;
      softLimitEn <= 1'b1;
      homeFault   <= 1'b0;
      absValid    <= 1'b0;
      home_done   <= 1'b0;
    end else begin
      moveEn      <= (state_nxt == ST_SEEK) || (state_nxt == ST_BACKOFF)
                  || (state_nxt == ST_PRESS);
      moveDirRev  <= (state_nxt == ST_BACKOFF) ? ~dirRev : dirRev;
      moveSpeed   <= speed_r;
      moveAccel   <= accel_r;
      torqueLimit <= ((state_nxt == ST_PRESS) || (state_nxt == ST_DWELL))
                   ? torque_r : TRQ_FULL;
      searchRun   <= (state_nxt == ST_NORMAL) || (state_nxt == ST_SEEK);
      softLimitEn <= ~((state_nxt == ST_SEEK) || (state_nxt == ST_BACKOFF)
                   || (state_nxt == ST_NORMAL));
      homeFault   <= fault_r;
      absValid    <= absEnable & ~incrMode & ~strokeless & ~absLost_r
                   & homeDone_r & revInRange;
      home_done   <= homeDone_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    prdata = '0;
    case (paddr)
      REG_CFG:     prdata = cfg_r;
      REG_HOMEPOS: prdata = homePos_r;
      REG_SPEED:   prdata = {16'h0000, speed_r};
      REG_DWELL:   prdata = {16'h0000, dwell_r};
      REG_TORQUE:  prdata = {16'h0000, torque_r};
      REG_ACCEL:   prdata = {16'h0000, accel_r};
      REG_STATUS:  prdata = {25'h0, state_r == ST_FAULT, absLost_r,
                             autoRet, homeMode, fault_r, absValid,
                             homeDone_r};
      REG_CURPOS:  prdata = curPos_r;
      REG_REVCNT:  prdata = {16'h0000, revCnt};
      default:     prdata = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_contact;
    state_r == ST_PRESS ##1 state_r == ST_DWELL;
  endsequence
  a_start_drops_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && !done_nxt |=> !homeDone_r)
    else $error("home done not cleared at start");
  a_torque_in_press: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == ST_PRESS |-> torqueLimit == torque_r)
    else $error("torque limit not applied while pressing");
  a_dwell_before_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_contact |-> !homeDone_r [*2])
    else $error("done raised before dwell ended");
  a_fault_far_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == ST_BACKOFF && atFarLimit |=> fault_r ##1 homeFault)
    else $error("fault not raised at far limit");
  a_soft_limit_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    autoRet |-> !softLimitEn)
    else $error("soft limit enabled during auto return");
  a_home_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done_nxt |=> curPos_r == $past(homePos_r) || $changed(encoderPos))
    else $error("home position not loaded");
  a_abs_incr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    incrMode && $past(incrMode) |-> !absValid)
    else $error("absolute valid in incremental mode");
  a_abs_stroke: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strokeless && $past(strokeless) |-> !absValid)
    else $error("absolute valid with strokeless axis");
  a_prox_backoff: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && proxSwitch && method == METH_DOG |=> state_r == ST_BACKOFF)
    else $error("no backoff from proximity switch");
  a_dataset_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    go && method == METH_DATASET |=> homeDone_r ##1 home_done)
    else $error("data setting did not complete");
endmodule // hrs_home_return_sequencer

// file: hrs_axis_model.sv
// Purpose: axis, switch and search model facing the sequencer
// Assumes: one count of travel per cycle while moving
// Notes:   dog and stopper presence is chosen by the bench
`timescale 1ns/100ps
module hrs_axis_model (
  input  wire logic        clk_sys,
  input  wire logic        moveEn,
  input  wire logic        moveDirRev,
  input  wire logic        searchRun,
  input  wire logic        dogOn,
  input  wire logic        stopOn,
  input  wire logic        load,
  input  wire logic [31:0] loadVal,
  output logic [31:0]      encoderPos,
  output logic             proxSwitch,
  output logic             limitFwd,
  output logic             limitRev,
  output logic             stopContact,
  output logic             searchDone
);
  int pos  = 0;
  int srch = 0;
  ////////////////////////////////////////////////////////////////////////////
  // travel, blocked forward while pressed on the stop
  always @(posedge clk_sys) begin
    if (load)
      pos <= int'(loadVal);
    else if (moveEn && (moveDirRev || !stopContact))
      pos <= moveDirRev ? pos - 1 : pos + 1;
    srch <= (searchRun && dogOn) ? srch + 1 : 0; // no dog, no search end
  end
  // switches and external search end
  assign encoderPos  = 32'(pos);
  assign proxSwitch  = dogOn && pos >= -20 && pos <= 20;
  assign limitFwd    = pos >= 200;
  assign limitRev    = pos <= -200;
  assign stopContact = stopOn && pos >= 60;
  assign searchDone  = srch == 16;
endmodule // hrs_axis_model

// file: hrs_home_return_sequencer_test.sv
// Purpose: self-checking bench for the home return sequencer
// Assumes: zero-wait apb slave, dwell of one millisecond
// Notes:   axis model stands in for motor, switches and search
`timescale 1ns/100ps
module hrs_home_return_sequencer_test;
  import hrs_pkg::*;
  logic        clk_sys = 0, rst_n = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, encoderPos, rd;
  logic        pready, pslverr, err;
  logic        auto_manual_select = 1, table_select_bit0 = 0;
  logic        table_select_bit1 = 0, homeStart = 0, servoOn = 0;
  logic        absEraseAlarm = 0, abs_counter_warning = 0;
  logic        dogOn = 0, stopOn = 0, load = 0;
  logic        proxSwitch, limitFwd, limitRev, stopContact, searchDone;
  logic        moveEn, moveDirRev, searchRun, softLimitEn;
  logic        home_done, homeFault, absValid;
  logic [15:0] moveSpeed, moveAccel, torqueLimit;
  int          mismatches = 0, checkCount = 0, n;
  logic [7:0]  ra[5] = '{REG_HOMEPOS, REG_TORQUE, REG_SPEED, REG_ACCEL, REG_DWELL};
  logic [31:0] rv[5] = '{32'h1234, 32'h30, 32'h10, 32'h22, 32'h1};
  logic [31:0] cf[3] = '{32'ha2, 32'hc2, 32'h82};

  hrs_home_return_sequencer uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .auto_manual_select(auto_manual_select),
    .table_select_bit0(table_select_bit0),
    .table_select_bit1(table_select_bit1), .homeStart(homeStart),
    .servoOn(servoOn), .proxSwitch(proxSwitch), .limitFwd(limitFwd),
    .limitRev(limitRev), .stopContact(stopContact),
    .searchDone(searchDone), .encoderPos(encoderPos),
    .absEraseAlarm(absEraseAlarm),
    .abs_counter_warning(abs_counter_warning), .moveEn(moveEn),
    .moveDirRev(moveDirRev), .moveSpeed(moveSpeed), .moveAccel(moveAccel),
    .torqueLimit(torqueLimit), .searchRun(searchRun),
    .softLimitEn(softLimitEn), .home_done(home_done),
    .homeFault(homeFault), .absValid(absValid));

  hrs_axis_model axis (.clk_sys(clk_sys), .moveEn(moveEn),
    .moveDirRev(moveDirRev), .searchRun(searchRun), .dogOn(dogOn),
    .stopOn(stopOn), .load(load), .loadVal(32'h0),
    .encoderPos(encoderPos), .proxSwitch(proxSwitch), .limitFwd(limitFwd),
    .limitRev(limitRev), .stopContact(stopContact),
    .searchDone(searchDone));

  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      mismatches++;
  endtask
  // start over the register bus, wait for home done
  task automatic go_wait(input int lim);
    apb(1'b1, REG_CTRL, 32'h1);
    for (n = 0; n < lim && home_done !== 1'b1; n++) @(posedge clk_sys);
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #(60000 * 50);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    testDone();
  end
  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(torqueLimit, TRQ_FULL);
    chk(softLimitEn, 1);
    apb(1'b0, REG_SPEED, 0);
    chk(rd, SPEED_RST);
    apb(1'b0, 8'h40, 0);
    chk(err, 1);
    chk(rd, 0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ra[i], rv[i]);
      apb(1'b0, ra[i], 0);
      chk(rd, rv[i]);
    end
    $display("registers done");
    apb(1'b1, REG_CFG, 32'h4);
    servoOn <= 1'b1;
    for (n = 0; n < 50 && home_done !== 1'b1; n++) @(posedge clk_sys);
    chk(home_done, 1);
    apb(1'b1, REG_CFG, 32'h3);
    table_select_bit0 <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (5) @(posedge clk_sys);
    chk({home_done, moveEn}, 2'b10);
    table_select_bit0 <= 1'b0;
    apb(1'b1, REG_CFG, 32'h2);
    apb(1'b1, REG_HOMEPOS, 32'h5678);
    go_wait(50);
    chk(home_done, 1);
    apb(1'b0, REG_CURPOS, 0);
    chk(rd, 32'h5678);
    $display("data set and servo-on done");
    apb(1'b1, REG_CFG, 32'h3);
    stopOn <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(home_done, 0);
    chk({moveEn, moveDirRev}, 2'b10);
    chk(moveSpeed, 16'h10);
    chk(moveAccel, 16'h22);
    chk(torqueLimit, 16'h30);
    for (n = 0; n < 200 && stopContact !== 1'b1; n++) @(posedge clk_sys);
    for (n = 0; n < 21000 && home_done !== 1'b1; n++) @(posedge clk_sys);
    chk(n >= MS_CYCLES && n <= MS_CYCLES + 8, 1);
    apb(1'b0, REG_CURPOS, 0);
    chk(rd, 32'h5678);
    $display("stopper done");
    stopOn <= 1'b0;
    dogOn <= 1'b1;
    load <= 1'b1;
    apb(1'b1, REG_CFG, 32'h0);
    load <= 1'b0;
    homeStart <= 1'b1;
    @(posedge clk_sys);
    homeStart <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({moveDirRev, softLimitEn, moveEn, searchRun}, 4'b1010);
    for (n = 0; n < 300 && home_done !== 1'b1; n++) @(posedge clk_sys);
    chk(home_done, 1);
    $display("dog done");
    dogOn <= 1'b0;
    load <= 1'b1;
    apb(1'b1, REG_CFG, 32'h1);
    load <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h1);
    for (n = 0; n < 1000 && homeFault !== 1'b1; n++) @(posedge clk_sys);
    chk({homeFault, moveEn}, 2'b10);
    chk($signed(encoderPos) inside {[-210 : -200]}, 1);
    apb(1'b1, REG_CTRL, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk(homeFault, 0);
    $display("fault done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, REG_CFG, cf[i]);
      go_wait(50);
      chk(absValid, i == 2);
    end
    apb(1'b1, REG_HOMEPOS, 32'h8000_0000);
    go_wait(50);
    repeat (2) @(posedge clk_sys);
    chk(absValid, 0);
    for (int i = 0; i < 2; i++) begin
      absEraseAlarm <= i == 0;
      abs_counter_warning <= i == 1;
      repeat (3) @(posedge clk_sys);
      chk(home_done, 0);
      absEraseAlarm <= 1'b0;
      abs_counter_warning <= 1'b0;
      go_wait(50);
      chk(home_done, 1);
    end
    $display("absolute done");
    testDone();
  end
endmodule // hrs_home_return_sequencer_test
